// ### rtl/bsc_link_if.sv
// link between the memory controller and the burst-2 sram device
`timescale 1ns/1ns
interface bsc_link_if;
  logic                        k_rise;                 // 1: true-clock edge, 0: complement
  logic                        load_strobe_n;
  logic                        rd_wr;                  // 1 read, 0 write
  logic [bsc_pkg::ADDR_W-1:0]  addr;
  logic [bsc_pkg::DATA_W-1:0]  d;
  logic [bsc_pkg::NSEL_W-1:0]  nibble_write_select_n;
  logic [bsc_pkg::BSEL_W-1:0]  byte_write_select_n;
  logic [bsc_pkg::DATA_W-1:0]  q;
  logic                        q_valid;
  logic                        q_word;                 // 0 even word, 1 odd word

  modport ctrl (
    output k_rise, load_strobe_n, rd_wr, addr, d, nibble_write_select_n, byte_write_select_n,
    input  q, q_valid, q_word
  );
  modport dev (
    input  k_rise, load_strobe_n, rd_wr, addr, d, nibble_write_select_n, byte_write_select_n,
    output q, q_valid, q_word
  );
endinterface

// ### rtl/bsc_mem_ctrl.sv
// memory controller end: register port in, burst-2 sram link out
`timescale 1ns/1ns
module bsc_mem_ctrl #(
  parameter logic [1:0] CFG = bsc_pkg::CFG_X36
) (
  input  wire logic                        core_clk_in,  // core clock
  input  wire logic                        rst_n_in,     // async reset, active low
  input  wire logic [7:0]                  reg_addr_in,  // register byte address
  input  wire logic [bsc_pkg::DATA_W-1:0]  reg_wdata_in, // register write data
  input  wire logic                        reg_wr_in,    // write strobe
  input  wire logic                        reg_rd_in,    // read strobe
  output      logic [bsc_pkg::DATA_W-1:0]  reg_rdata_out, // read data, cycle after strobe
  bsc_link_if.ctrl                         link          // device side
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_W0   = 5'h04,
    ST_W1   = 5'h08,
    ST_RD   = 5'h10
  } bsc_state_t;

  bsc_state_t                 state_reg;
  bsc_state_t                 state_next;
  logic                       go_reg;
  logic                       dir_reg;
  logic [bsc_pkg::ADDR_W-1:0] addr_reg;
  logic [bsc_pkg::DATA_W-1:0] wdata0_reg;
  logic [bsc_pkg::DATA_W-1:0] wdata1_reg;
  logic [7:0]                 sel_reg;
  logic [bsc_pkg::DATA_W-1:0] rdata0_reg;
  logic [bsc_pkg::DATA_W-1:0] rdata1_reg;
  logic                       rdone_reg;
  logic                       wdone_reg;
  logic [bsc_pkg::DATA_W-1:0] rdata_reg;
  logic                       k_rise_reg;
  logic                       load_n_reg;
  logic                       rd_wr_reg;
  logic [bsc_pkg::ADDR_W-1:0] link_addr_reg;
  logic [bsc_pkg::DATA_W-1:0] d_reg;
  logic [3:0]                 wsel_reg;

  wire logic                  wr_ctrl   = reg_wr_in & (reg_addr_in == bsc_pkg::REG_CTRL);
  wire logic                  wr_status = reg_wr_in & (reg_addr_in == bsc_pkg::REG_STATUS);
  wire logic                  busy      = (state_reg != ST_IDLE);
  // a load may only leave on the cycle that becomes a true-clock edge
  wire logic                  launch    = (state_reg == ST_IDLE) & go_reg & ~k_rise_reg;
  wire logic                  rd_last   = link.q_valid & link.q_word;
  wire logic [bsc_pkg::DATA_W-1:0] status_word =
    bsc_pkg::DATA_W'({wdone_reg, rdone_reg, busy});
  wire logic [bsc_pkg::DATA_W-1:0] rd_mux =
    (reg_addr_in == bsc_pkg::REG_CTRL)   ? bsc_pkg::DATA_W'({dir_reg, go_reg}) :
    (reg_addr_in == bsc_pkg::REG_ADDR)   ? bsc_pkg::DATA_W'(addr_reg) :
    (reg_addr_in == bsc_pkg::REG_WDATA0) ? wdata0_reg :
    (reg_addr_in == bsc_pkg::REG_WDATA1) ? wdata1_reg :
    (reg_addr_in == bsc_pkg::REG_SEL)    ? bsc_pkg::DATA_W'(sel_reg) :
    (reg_addr_in == bsc_pkg::REG_RDATA0) ? rdata0_reg :
    (reg_addr_in == bsc_pkg::REG_RDATA1) ? rdata1_reg :
    (reg_addr_in == bsc_pkg::REG_STATUS) ? status_word : '0;

  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = launch ? ST_LOAD : ST_IDLE;
      ST_LOAD: state_next = dir_reg ? ST_RD : ST_W0;
      ST_W0:   state_next = ST_W1;
      ST_W1:   state_next = ST_IDLE;
      ST_RD:   state_next = rd_last ? ST_IDLE : ST_RD;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      k_rise_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      k_rise_reg <= ~k_rise_reg;
    end
  end

  // software registers; go clears itself once the load is on the link
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      go_reg     <= 1'b0;
      dir_reg    <= bsc_pkg::DIR_WRITE;
      addr_reg   <= '0;
      wdata0_reg <= '0;
      wdata1_reg <= '0;
      sel_reg    <= bsc_pkg::SEL_RESET;
      rdata_reg  <= '0;
    end else begin
      if (wr_ctrl) begin
        go_reg  <= reg_wdata_in[bsc_pkg::CTRL_GO_BIT];
        dir_reg <= reg_wdata_in[bsc_pkg::CTRL_DIR_BIT];
      end else if (launch) begin
        go_reg <= 1'b0;
      end
      if (reg_wr_in && reg_addr_in == bsc_pkg::REG_ADDR) begin
        addr_reg <= reg_wdata_in[bsc_pkg::ADDR_W-1:0];
      end
      if (reg_wr_in && reg_addr_in == bsc_pkg::REG_WDATA0) begin
        wdata0_reg <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == bsc_pkg::REG_WDATA1) begin
        wdata1_reg <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == bsc_pkg::REG_SEL) begin
        sel_reg <= reg_wdata_in[7:0];
      end
      if (reg_rd_in) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // done flags: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdone_reg  <= 1'b0;
      wdone_reg  <= 1'b0;
      rdata0_reg <= '0;
      rdata1_reg <= '0;
    end else begin
      if (link.q_valid && !link.q_word) begin
        rdata0_reg <= link.q;
      end
      if (rd_last) begin
        rdata1_reg <= link.q;
      end
      rdone_reg <= rd_last | (rdone_reg & ~(wr_status & reg_wdata_in[bsc_pkg::ST_RDONE_BIT]));
      wdone_reg <= (state_reg == ST_W1) |
                   (wdone_reg & ~(wr_status & reg_wdata_in[bsc_pkg::ST_WDONE_BIT]));
    end
  end

  // link drive: load and address with the true edge, then two data beats on a write
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_n_reg    <= 1'b1;
      rd_wr_reg     <= bsc_pkg::DIR_READ;
      link_addr_reg <= '0;
      d_reg         <= '0;
      wsel_reg      <= bsc_pkg::SEL_IDLE;
    end else begin
      load_n_reg <= ~launch;
      if (launch) begin
        rd_wr_reg     <= dir_reg;
        link_addr_reg <= addr_reg;
      end
      if (state_reg == ST_LOAD && !dir_reg) begin
        d_reg    <= wdata0_reg;
        wsel_reg <= sel_reg[3:0];
      end else if (state_reg == ST_W0) begin
        d_reg    <= wdata1_reg;
        wsel_reg <= sel_reg[7:4];
      end else begin
        wsel_reg <= bsc_pkg::SEL_IDLE;
      end
    end
  end

  assign reg_rdata_out              = rdata_reg;
  assign link.k_rise                = k_rise_reg;
  assign link.load_strobe_n         = load_n_reg;
  assign link.rd_wr                 = rd_wr_reg;
  assign link.addr                  = link_addr_reg;
  assign link.d                     = d_reg;
  // nibble selects only exist in the x8 width, byte selects in the others
  assign link.nibble_write_select_n = (CFG == bsc_pkg::CFG_X8) ? wsel_reg[1:0] : 2'h3;
  assign link.byte_write_select_n   = (CFG == bsc_pkg::CFG_X8) ? 4'hF : wsel_reg;

endmodule

// ### rtl/bsc_pkg.sv
// shared constants, configuration codes and lane decoding for both burst-2 sram ends
// Behaviour
// - load strobe low defines a new transaction
// - every transaction moves exactly two words
// - x8 nibble selects mask each word nibble
// - other widths: byte selects mask each byte
// - byte select n governs nine-bit lane n
// - selects travel and sample with their word
// - address captured only on true clock edge
// - one address bus serves reads and writes
// - two half-depth arrays hold the word pair
// - address width 22, 21 or 20 bits
// - address ignored unless port is selected
// - direction high reads, low writes
// - write data sampled on both edges
package bsc_pkg;
  localparam int          DATA_W        = 36;
  localparam int          ADDR_W        = 22;
  localparam int          BSEL_W        = 4;
  localparam int          NSEL_W        = 2;
  localparam int          LANE_W        = 9;
  localparam int          NIB_W         = 4;
  // data width configurations
  localparam logic [1:0]  CFG_X8        = 2'h0;
  localparam logic [1:0]  CFG_X9        = 2'h1;
  localparam logic [1:0]  CFG_X18       = 2'h2;
  localparam logic [1:0]  CFG_X36       = 2'h3;
  localparam int          AW_X8_X9      = 22;
  localparam int          AW_X18        = 21;
  localparam int          AW_X36        = 20;
  localparam logic        DIR_READ      = 1'h1;
  localparam logic        DIR_WRITE     = 1'h0;
  // controller register map, byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_ADDR      = 8'h04;
  localparam logic [7:0]  REG_WDATA0    = 8'h08;
  localparam logic [7:0]  REG_WDATA1    = 8'h0C;
  localparam logic [7:0]  REG_SEL       = 8'h10;
  localparam logic [7:0]  REG_RDATA0    = 8'h14;
  localparam logic [7:0]  REG_RDATA1    = 8'h18;
  localparam logic [7:0]  REG_STATUS    = 8'h1C;
  localparam int          CTRL_GO_BIT   = 0;
  localparam int          CTRL_DIR_BIT  = 1;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_RDONE_BIT  = 1;
  localparam int          ST_WDONE_BIT  = 2;
  localparam logic [7:0]  SEL_RESET     = 8'h00;
  localparam logic [3:0]  SEL_IDLE      = 4'hF;

  function automatic int addr_width(input logic [1:0] cfg);
    int w;
    w = AW_X36;
    case (cfg)
      CFG_X8, CFG_X9: w = AW_X8_X9;
      CFG_X18:        w = AW_X18;
      default:        w = AW_X36;
    endcase
    return w;
  endfunction

  // write enable per data bit from the active-low selects of one word
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] cfg,
                                                   input logic [NSEL_W-1:0] nib_n,
                                                   input logic [BSEL_W-1:0] byte_n);
    logic [DATA_W-1:0] m;
    m = '0;
    case (cfg)
      CFG_X8: begin
        m[NIB_W-1:0]       = {NIB_W{~nib_n[0]}};
        m[2*NIB_W-1:NIB_W] = {NIB_W{~nib_n[1]}};
      end
      CFG_X9:  m[LANE_W-1:0] = {LANE_W{~byte_n[0]}};
      CFG_X18: begin
        m[LANE_W-1:0]        = {LANE_W{~byte_n[0]}};
        m[2*LANE_W-1:LANE_W] = {LANE_W{~byte_n[1]}};
      end
      default: begin
        for (int i = 0; i < BSEL_W; i++) begin
          m[i*LANE_W +: LANE_W] = {LANE_W{~byte_n[i]}};
        end
      end
    endcase
    return m;
  endfunction
endpackage

// ### rtl/bsc_sram_dev.sv
// burst-2 separate-io sram device: load, address, select masking and two-array store
`timescale 1ns/1ns
module bsc_sram_dev #(
  parameter logic [1:0] CFG      = bsc_pkg::CFG_X36,
  // store depth per array in address bits; lower it to keep simulation memory small
  parameter int         STORE_AW = bsc_pkg::addr_width(CFG)
) (
  input  wire logic                        core_clk_in,   // core clock
  input  wire logic                        rst_n_in,      // async reset, active low
  bsc_link_if.dev                          link,          // controller side
  output      logic                        txn_out,       // pulse: transaction loaded
  output      logic                        txn_read_out,  // direction of last load
  output      logic [bsc_pkg::ADDR_W-1:0]  txn_addr_out   // address of last load
);
  localparam int AW = bsc_pkg::addr_width(CFG);

  // one location holds the burst pair: even word in one array, odd in the other
  logic [bsc_pkg::DATA_W-1:0] mem_even [0:(1<<STORE_AW)-1];
  logic [bsc_pkg::DATA_W-1:0] mem_odd  [0:(1<<STORE_AW)-1];

  logic [bsc_pkg::ADDR_W-1:0] addr_reg;
  logic [bsc_pkg::ADDR_W-1:0] addr_next;
  logic                       wr0_reg;
  logic                       wr1_reg;
  logic                       rd0_reg;
  logic                       rd1_reg;
  logic [bsc_pkg::DATA_W-1:0] q_reg;
  logic [bsc_pkg::DATA_W-1:0] q_next;
  logic                       q_valid_reg;
  logic                       q_word_reg;
  logic                       txn_reg;
  logic                       txn_read_reg;

  wire logic                  load_take;
  wire logic                  is_read;
  wire logic [bsc_pkg::ADDR_W-1:0] addr_in_masked;
  wire logic [STORE_AW-1:0]   store_idx;
  wire logic [bsc_pkg::DATA_W-1:0] wmask;
  wire logic                  wr_even;
  wire logic                  wr_odd;

  // loads are taken only on the true-clock edge with the strobe low
  assign load_take = link.k_rise & ~link.load_strobe_n;
  assign is_read   = (link.rd_wr == bsc_pkg::DIR_READ);

  // upper address pins beyond the configured width carry no meaning
  assign addr_in_masked = link.addr & bsc_pkg::ADDR_W'((64'h1 << AW) - 64'h1);
  assign addr_next      = load_take ? addr_in_masked : addr_reg;
  assign store_idx      = addr_reg[STORE_AW-1:0];

  // selects are decoded from the same sample as the data word they mask
  assign wmask = bsc_pkg::lane_mask(CFG, link.nibble_write_select_n,
                                    link.byte_write_select_n);

  // even word on the complement edge after load, odd word on the next true edge
  assign wr_even = wr0_reg & ~link.k_rise;
  assign wr_odd  = wr1_reg & link.k_rise;

  always_comb begin
    q_next = q_reg;
    if (rd0_reg) begin
      q_next = mem_even[store_idx];
    end else if (rd1_reg) begin
      q_next = mem_odd[store_idx];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // burst sequencer: a load opens exactly two data beats, then closes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr0_reg <= 1'b0;
      wr1_reg <= 1'b0;
      rd0_reg <= 1'b0;
      rd1_reg <= 1'b0;
    end else begin
      wr0_reg <= load_take & ~is_read;
      wr1_reg <= wr_even;
      rd0_reg <= load_take & is_read;
      rd1_reg <= rd0_reg;
    end
  end

  // masked writes: unselected lanes keep their stored bits
  always_ff @(posedge core_clk_in) begin
    if (wr_even) begin
      mem_even[store_idx] <= (mem_even[store_idx] & ~wmask) | (link.d & wmask);
    end
    if (wr_odd) begin
      mem_odd[store_idx] <= (mem_odd[store_idx] & ~wmask) | (link.d & wmask);
    end
  end

  // read beats mirror the write beats, but the q register puts each read word one cycle behind its beat
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_reg       <= '0;
      q_valid_reg <= 1'b0;
      q_word_reg  <= 1'b0;
    end else begin
      q_reg       <= q_next;
      q_valid_reg <= rd0_reg | rd1_reg;
      q_word_reg  <= rd1_reg;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txn_reg      <= 1'b0;
      txn_read_reg <= 1'b0;
    end else begin
      txn_reg <= load_take;
      if (load_take) begin
        txn_read_reg <= is_read;
      end
    end
  end

  assign link.q       = q_reg;
  assign link.q_valid = q_valid_reg;
  assign link.q_word  = q_word_reg;
  assign txn_out      = txn_reg;
  assign txn_read_out = txn_read_reg;
  assign txn_addr_out = addr_reg;

endmodule

// ### verification/bsc_link_assertions.sv
// concurrent checks on the link between controller and sram device
`timescale 1ns/1ns
module bsc_link_assertions (
  input wire logic                        core_clk_in,           // core clock
  input wire logic                        rst_n_in,              // async reset, active low
  input wire logic                        k_rise,                // true-clock edge flag
  input wire logic                        load_strobe_n,         // load, active low
  input wire logic                        rd_wr,                 // 1 read, 0 write
  input wire logic [bsc_pkg::ADDR_W-1:0]  addr,                  // address
  input wire logic [bsc_pkg::DATA_W-1:0]  d,                     // write data
  input wire logic [bsc_pkg::NSEL_W-1:0]  nibble_write_select_n, // nibble selects
  input wire logic [bsc_pkg::BSEL_W-1:0]  byte_write_select_n,   // byte selects
  input wire logic [bsc_pkg::DATA_W-1:0]  q,                     // read word
  input wire logic                        q_valid,               // read word valid
  input wire logic                        q_word                 // odd word flag
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire rd_load = !load_strobe_n && rd_wr;
  wire wr_load = !load_strobe_n && !rd_wr;

  property p_load_on_k; !load_strobe_n |-> k_rise; endproperty
  a_load_on_k: assert property (p_load_on_k) else $error("load off true edge");
  // the first edge after release still sees the reset value twice
  property p_k_toggle; $past(rst_n_in) |-> k_rise != $past(k_rise); endproperty
  a_k_toggle: assert property (p_k_toggle) else $error("edge flag stuck");
  property p_no_b2b; !load_strobe_n |=> load_strobe_n; endproperty
  a_no_b2b: assert property (p_no_b2b) else $error("back to back load");
  property p_read_pair;
    rd_load |-> ##[1:2] (q_valid && !q_word) ##1 (q_valid && q_word);
  endproperty
  a_read_pair: assert property (p_read_pair) else $error("read burst wrong");
  property p_q_odd; q_valid && q_word |-> $past(q_valid) && !$past(q_word); endproperty
  a_q_odd: assert property (p_q_odd) else $error("odd word unpaired");
  property p_q_cause; q_valid && !q_word |-> $past(rd_load) || $past(rd_load, 2); endproperty
  a_q_cause: assert property (p_q_cause) else $error("read without load");
  property p_write_beats;
    wr_load |=> !k_rise ##1 k_rise ##1 (byte_write_select_n == bsc_pkg::SEL_IDLE);
  endproperty
  a_write_beats: assert property (p_write_beats) else $error("write beats wrong");
  property p_sel_window;
    byte_write_select_n != bsc_pkg::SEL_IDLE |-> $past(wr_load) || $past(wr_load, 2);
  endproperty
  a_sel_window: assert property (p_sel_window) else $error("select outside write");

  c_read: cover property (rd_load);
  c_write: cover property (wr_load);
  c_partial: cover property (byte_write_select_n != 4'hF && byte_write_select_n != 4'h0);
endmodule

// ### verification/test_burst2_sram_control_inputs.sv
// self-checking bench: controller and device back to back, memory model in the bench
`timescale 1ns/1ns
module test_burst2_sram_control_inputs;
  logic        core_clk_in;
  logic        rst_n_in;
  logic [7:0]  reg_addr;
  logic [35:0] reg_wdata;
  logic [35:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        txn;
  logic        txn_rd;
  logic [21:0] txn_addr;
  logic [35:0] reg_rdata8;
  logic        txn8;
  logic        txn_rd8;
  logic [21:0] txn_addr8;
  int          fails;
  int          checked;
  int          ops;
  int          txns;
  int          txns8;
  logic [35:0] mem0 [64];
  logic [35:0] mem1 [64];
  logic [7:0]  mem8_0 [64];
  logic [7:0]  mem8_1 [64];

  bsc_link_if bsc_link_if_i ();
  bsc_mem_ctrl #(.CFG(bsc_pkg::CFG_X36)) bsc_mem_ctrl_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .link(bsc_link_if_i));
  // small store keeps simulation memory low; addresses wrap on the low six bits
  bsc_sram_dev #(.CFG(bsc_pkg::CFG_X36), .STORE_AW(6)) bsc_sram_dev_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(bsc_link_if_i),
    .txn_out(txn), .txn_read_out(txn_rd), .txn_addr_out(txn_addr));
  // nibble-select pair shares the register port and runs in lock step with the x36 pair
  bsc_link_if bsc_link_if_x8_i ();
  bsc_mem_ctrl #(.CFG(bsc_pkg::CFG_X8)) bsc_mem_ctrl_x8_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata8), .link(bsc_link_if_x8_i));
  bsc_sram_dev #(.CFG(bsc_pkg::CFG_X8), .STORE_AW(6)) bsc_sram_dev_x8_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(bsc_link_if_x8_i),
    .txn_out(txn8), .txn_read_out(txn_rd8), .txn_addr_out(txn_addr8));
  bsc_link_assertions bsc_link_assertions_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .k_rise(bsc_link_if_i.k_rise),
    .load_strobe_n(bsc_link_if_i.load_strobe_n), .rd_wr(bsc_link_if_i.rd_wr),
    .addr(bsc_link_if_i.addr), .d(bsc_link_if_i.d),
    .nibble_write_select_n(bsc_link_if_i.nibble_write_select_n),
    .byte_write_select_n(bsc_link_if_i.byte_write_select_n), .q(bsc_link_if_i.q),
    .q_valid(bsc_link_if_i.q_valid), .q_word(bsc_link_if_i.q_word));

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (txn === 1'b1) txns++;
  always @(posedge core_clk_in) if (txn8 === 1'b1) txns8++;

  task automatic stop_test;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [35:0] v);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [35:0] v);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_in);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // active-low selects, one per nine-bit lane
  function automatic logic [35:0] lmask(input logic [3:0] s);
    logic [35:0] m;
    for (int i = 0; i < 4; i++) m[i*9 +: 9] = {9{~s[i]}};
    return m;
  endfunction
  task automatic run(input logic dir, input logic [21:0] a, input logic [35:0] w0,
                     input logic [35:0] w1, input logic [7:0] s);
    logic [35:0] v;
    int          k;
    int          b;
    int          n;
    logic [7:0]  m8;
    k = a[5:0];
    b = dir ? bsc_pkg::ST_RDONE_BIT : bsc_pkg::ST_WDONE_BIT;
    n = 0;
    v = '0;
    wr(bsc_pkg::REG_ADDR, {14'h0000, a});
    wr(bsc_pkg::REG_WDATA0, w0);
    wr(bsc_pkg::REG_WDATA1, w1);
    wr(bsc_pkg::REG_SEL, {28'h0000000, s});
    wr(bsc_pkg::REG_CTRL, {34'h000000000, dir, 1'b1});
    while (v[b] !== 1'b1 && n < 40) begin
      rd(bsc_pkg::REG_STATUS, v);
      n++;
    end
    chk({35'h0, v[b]}, 36'h1);
    wr(bsc_pkg::REG_STATUS, 36'h1 << b);
    if (dir) begin
      rd(bsc_pkg::REG_RDATA0, v);
      chk(v, mem0[k]);
      chk({28'h0, reg_rdata8[7:0]}, {28'h0, mem8_0[k]});
      rd(bsc_pkg::REG_RDATA1, v);
      chk(v, mem1[k]);
      chk({28'h0, reg_rdata8[7:0]}, {28'h0, mem8_1[k]});
    end else begin
      mem0[k] = (mem0[k] & ~lmask(s[3:0])) | (w0 & lmask(s[3:0]));
      mem1[k] = (mem1[k] & ~lmask(s[7:4])) | (w1 & lmask(s[7:4]));
      // x8: nibble selects are the low two selects of each word
      m8 = {{4{~s[1]}}, {4{~s[0]}}};
      mem8_0[k] = (mem8_0[k] & ~m8) | (w0[7:0] & m8);
      m8 = {{4{~s[5]}}, {4{~s[4]}}};
      mem8_1[k] = (mem8_1[k] & ~m8) | (w1[7:0] & m8);
    end
    chk({14'h0000, txn_addr}, {14'h0000, a & 22'h0FFFFF});
    chk({14'h0000, txn_addr8}, {14'h0000, a});
    chk({35'h0, txn_rd}, {35'h0, dir});
    chk({35'h0, txn_rd8}, {35'h0, dir});
    ops++;
  endtask

  initial begin
    logic [21:0] a;
    logic [35:0] v;
    rst_n_in = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    checked = 0;
    ops = 0;
    txns = 0;
    txns8 = 0;
    void'($urandom(15));
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = 22'($urandom);
      a[5:0] = 6'(i);
      run(1'b0, a, {4'($urandom), $urandom}, {4'($urandom), $urandom}, 8'h00);
    end
    run(1'b0, 22'h000007, 36'h0, 36'h0, 8'hFF);
    run(1'b1, 22'h000007, 36'h0, 36'h0, 8'h00);
    repeat (30) begin
      a = 22'($urandom);
      a[5:0] = 6'($urandom_range(7, 0));
      run(1'($urandom), a, {4'($urandom), $urandom}, {4'($urandom), $urandom},
          8'($urandom));
    end
    for (int i = 0; i < 8; i++) run(1'b1, 22'(i), 36'h0, 36'h0, 8'h00);
    rd(8'h20, v);
    chk(v, 36'h0);
    repeat (4) @(posedge core_clk_in);
    chk(36'(txns), 36'(ops));
    chk(36'(txns8), 36'(ops));
    stop_test;
  end
  initial begin
    #800000;
    fails++;
    stop_test;
  end
endmodule
